// ===== bench/spc_counter_bench.sv
/*
  Self-checking bench: register accesses and count bursts.
  Runs a decade, synchronous-clear build and a binary, immediate-clear
  build side by side on one bus and one count clock pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
module spc_counter_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [3:0]  adr   = 4'h0;
  logic [3:0]  sel   = 4'h1;
  logic [31:0] wdat  = 32'h0;
  logic [4:0]  n     = 5'h0;
  logic        start = 1'b0;
  logic [31:0] rdat;
  logic [31:0] rdat2;
  logic [31:0] q;
  logic [31:0] q2;
  logic        ack;
  logic        cclk;
  logic        busy;
  logic        carry;
  logic        carry2;
  logic [3:0]  cnt;
  logic [3:0]  cnt2;
  int          err_total  = 0;
  int          n_compared = 0;
  always #20 clk_i = ~clk_i;
  // Decade build, clear waits for the count edge
  spc_counter #(.DECADE(1'b1), .SYNC_CLEAR(1'b1)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .count_clk_i(cclk), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .count_o(cnt),
    .carry_o(carry));
  // Binary build, immediate clear; same bus logic, so its ack matches
  spc_counter #(.DECADE(1'b0), .SYNC_CLEAR(1'b0)) i_dut2 (
    .clk_i(clk_i), .rst_i(rst_i), .count_clk_i(cclk), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat2), .wb_ack_o(), .count_o(cnt2),
    .carry_o(carry2));
  spc_pulser i_src (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
    .n_i(n), .count_clk_o(cclk), .busy_o(busy));
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // ************************************************************
  // Classic single Wishbone cycle, held until ack
  // ************************************************************
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    // A missing ack counts as a mismatch and ends the run
    if (ack !== 1'b1) begin
      err_total++;
      end_of_test();
    end else begin
      q   = rdat;
      q2  = rdat2;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask
  // Read one register of both builds and compare each
  task automatic rd(input logic [3:0] a, input logic [31:0] e1,
                    input logic [31:0] e2);
    wb(1'b0, a, 32'h0);
    chk(q, e1);
    chk(q2, e2);
  endtask
  // Burst of count edges, then status of both builds read back
  task automatic pulse(input logic [4:0] p, input logic [31:0] e1,
                       input logic [31:0] e2);
    int k;
    k = 0;
    @(posedge clk_i);
    start <= 1'b1;
    n     <= p;
    @(posedge clk_i);
    start <= 1'b0;
    do begin
      @(posedge clk_i);
      k++;
    end while (busy !== 1'b0 && k < 200);
    if (busy !== 1'b0) begin
      err_total++;
      end_of_test();
    end else begin
      rd(`SPC_STATUS_OFS, e1, e2);
    end
  endtask
  // Expected pairs: decade synchronous build, then binary immediate build
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SPC_CTRL_OFS, 32'h0c, 32'h0c);
    rd(4'h8, 32'h0, 32'h0);
    wb(1'b1, `SPC_CTRL_OFS, 32'h0d);  // Trickle enable low blocks counting
    pulse(5'd1, 32'h00, 32'h00);
    wb(1'b1, `SPC_CTRL_OFS, 32'h0f);  // Both enables, no load or clear
    pulse(5'd9, 32'h19, 32'h09);
    pulse(5'd1, 32'h00, 32'h0a);
    wb(1'b1, `SPC_CTRL_OFS, 32'h7b);  // Preset 7, load low, counting on
    rd(`SPC_STATUS_OFS, 32'h00, 32'h0a);
    pulse(5'd1, 32'h07, 32'h07);
    wb(1'b1, `SPC_CTRL_OFS, 32'h73);  // Clear and load both low
    rd(`SPC_STATUS_OFS, 32'h07, 32'h00);
    pulse(5'd1, 32'h00, 32'h00);
    wb(1'b1, `SPC_CTRL_OFS, 32'h9b);
    pulse(5'd1, 32'h19, 32'h09);
    wb(1'b1, `SPC_CTRL_OFS, 32'h9c);  // Carry drops with trickle enable
    rd(`SPC_STATUS_OFS, 32'h09, 32'h09);
    chk({27'h0, carry, cnt}, 32'h09);
    chk({27'h0, carry2, cnt2}, 32'h09);
    wb(1'b1, `SPC_STATUS_OFS, 32'hff);  // Status is read only
    rd(`SPC_STATUS_OFS, 32'h09, 32'h09);
    sel <= 4'h0;                      // Byte lane off: write ignored
    wb(1'b1, `SPC_CTRL_OFS, 32'h0f);
    sel <= 4'h1;
    rd(`SPC_CTRL_OFS, 32'h9c, 32'h9c);
    wb(1'b1, `SPC_CTRL_OFS, 32'hfb);  // Preset 15, load low
    pulse(5'd1, 32'h0f, 32'h1f);
    wb(1'b1, `SPC_CTRL_OFS, 32'h0f);
    pulse(5'd1, 32'h00, 32'h00);
    pulse(5'd16, 32'h06, 32'h00);
    end_of_test();
  end
endmodule // spc_counter_bench
`default_nettype wire

// ===== bench/spc_pulser.sv
/*
  Count clock source standing in for the surrounding control logic.
  Assumes start_i is held for one clk_i cycle with n_i stable.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_pulser (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [4:0] n_i,
  output logic            count_clk_o,
  output logic            busy_o
);
  // Pin rests low between bursts; 3 cycles each phase meets the sync need
  always begin
    @(posedge clk_i);
    if (rst_i) begin
      count_clk_o <= 1'b0;
      busy_o      <= 1'b0;
    end else if (start_i) begin
      busy_o <= 1'b1;
      repeat (n_i) begin
        count_clk_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        count_clk_o <= 1'b0;
        repeat (3) @(posedge clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule // spc_pulser
`default_nettype wire

// ===== verilog/spc_counter.sv
/*
  Presettable 4-bit counter with look-ahead carry, decade or binary,
  synchronous or immediate clear, registers on classic Wishbone.
  Assumes a master that holds each request until ack, and a count
  clock pin asynchronous to clk_i and well below clk_i / 4.
*/
// Operation
// - Decade variant counts ten BCD states, binary variant all sixteen.
// - From zero, msb and carry return after ten or sixteen counts.
// - All four bits change together on one common edge, no ripple.
// - State changes only on the rising count clock edge, except for an immediate clear.
// - Count advances only when enables permit; otherwise state holds.
// - Carry follows trickle enable and count state directly, no extra edge.
// - Load low captures preset inputs into the counter on a clock edge.
// - Synchronous variant clears on next edge; other variant clears at once.
// - Clear drives every count bit low.
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"

module spc_counter #(
  parameter bit DECADE     = 1'b1,
  parameter bit SYNC_CLEAR = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        count_clk_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [3:0]  count_o,
  output logic             carry_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Next count; decade wraps at nine, binary at fifteen
  function automatic logic [3:0] spc_incr(input logic [3:0] c);
    if (DECADE && c == `SPC_TERM_DEC)
      return `SPC_ZERO;
    return c + `SPC_ONE;
  endfunction

  function automatic logic spc_is_term(input logic [3:0] c);
    return c == (DECADE ? `SPC_TERM_DEC : `SPC_TERM_BIN);
  endfunction

  // ************************************************************
  // Count clock synchroniser and rising edge
  // ************************************************************
  logic clk_sync1;
  logic clk_sync2;
  logic clk_prev;
  logic cnt_edge;

  // Two flops before any logic looks at the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sync1 <= 1'b0;
      clk_sync2 <= 1'b0;
      clk_prev  <= 1'b0;
    end else begin
      clk_sync1 <= count_clk_i;
      clk_sync2 <= clk_sync1;
      clk_prev  <= clk_sync2;
    end
  end

  // Falling edge is ignored on purpose
  assign cnt_edge = clk_sync2 & ~clk_prev;

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  spc_pkg::spc_ctrl_t ctrl;
  spc_pkg::spc_ctrl_t next_ctrl;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        wr_en;
  logic        sel_ctrl;
  logic        sel_stat;

  assign sel_ctrl = wb_adr_i == `SPC_CTRL_OFS;
  assign sel_stat = wb_adr_i == `SPC_STATUS_OFS;
  // Write lands on the edge where ack is seen
  assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // One wait state, ack drops after one cycle; unmapped reads zero
  always_comb begin
    next_ack  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat  = 32'h0000_0000;
    next_ctrl = ctrl;
    if (sel_ctrl)
      next_dat[`SPC_CTRL_W-1:0] = ctrl;
    else if (sel_stat)
      next_dat[`SPC_STAT_CARRY:0] = {carry_o, count_o};
    if (wr_en && sel_ctrl && wb_sel_i[0])
      next_ctrl = wb_dat_i[`SPC_CTRL_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl     <= `SPC_CTRL_RST;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      ctrl     <= next_ctrl;
    end
  end

  // ************************************************************
  // Counter core
  // ************************************************************
  logic [3:0] next_count;
  logic       next_carry;

  // Priority clear, load, count; next_ctrl lets an immediate clear
  // act on the very edge of the bus write
  always_comb begin
    next_count = count_o;
    if (!SYNC_CLEAR && !next_ctrl.clear_n)
      next_count = `SPC_ZERO;
    else if (cnt_edge) begin
      if (!ctrl.clear_n)
        next_count = `SPC_ZERO;
      else if (!ctrl.load_n)
        next_count = ctrl.preset;
      else if (ctrl.en_p && ctrl.en_t)
        next_count = spc_incr(count_o);
    end
    // Look-ahead carry, built from next values so it stays a flop
    next_carry = next_ctrl.en_t & spc_is_term(next_count);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= `SPC_ZERO;
      carry_o <= 1'b0;
    end else begin
      count_o <= next_count;
      carry_o <= next_carry;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  logic counting;
  assign counting = cnt_edge & ctrl.clear_n & ctrl.load_n & ctrl.en_p
                  & ctrl.en_t & ~wr_en;

  property p_carry_term;
    @(posedge clk_i) disable iff (rst_i)
      carry_o == (ctrl.en_t && spc_is_term(count_o));
  endproperty
  a_carry_term: assert property (p_carry_term)
    else $error("carry does not match en_t and terminal count");

  property p_hold_no_edge;
    @(posedge clk_i) disable iff (rst_i)
      (!cnt_edge && !wr_en) |=> $stable(count_o);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge)
    else $error("count changed without a rising count edge");

  property p_count_step;
    @(posedge clk_i) disable iff (rst_i)
      counting |=> count_o == spc_incr($past(count_o));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not advance by one");

  property p_inhibit;
    @(posedge clk_i) disable iff (rst_i)
      (cnt_edge && ctrl.clear_n && ctrl.load_n && !wr_en
       && !(ctrl.en_p && ctrl.en_t)) |=> $stable(count_o);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("count moved with an enable low");

  property p_load;
    @(posedge clk_i) disable iff (rst_i)
      (cnt_edge && ctrl.clear_n && !ctrl.load_n && !wr_en)
        |=> count_o == $past(ctrl.preset);
  endproperty
  a_load: assert property (p_load)
    else $error("preset not loaded");

  property p_sync_clear;
    @(posedge clk_i) disable iff (rst_i)
      (SYNC_CLEAR && cnt_edge && !ctrl.clear_n) |=> count_o == `SPC_ZERO;
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("clear did not win at the count edge");

  property p_imm_clear;
    @(posedge clk_i) disable iff (rst_i)
      (!SYNC_CLEAR && !ctrl.clear_n) |-> count_o == `SPC_ZERO;
  endproperty
  a_imm_clear: assert property (p_imm_clear)
    else $error("immediate clear left a bit high");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
      (counting && spc_is_term(count_o)) |=> count_o == `SPC_ZERO
        && !carry_o;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap from terminal state");

  property p_decade_range;
    @(posedge clk_i) disable iff (rst_i)
      (DECADE && counting && count_o <= `SPC_TERM_DEC)
        |=> count_o <= `SPC_TERM_DEC;
  endproperty
  a_decade_range: assert property (p_decade_range)
    else $error("decade counter left the BCD range");

  property p_together;
    @(posedge clk_i) disable iff (rst_i)
      $changed(count_o) |-> $past(cnt_edge) || $past(wr_en);
  endproperty
  a_together: assert property (p_together)
    else $error("count changed outside a common edge");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  c_wrap:  cover property (@(posedge clk_i) disable iff (rst_i)
                           counting && spc_is_term(count_o));
  c_load:  cover property (@(posedge clk_i) disable iff (rst_i)
                           cnt_edge && ctrl.clear_n && !ctrl.load_n);
  c_clear: cover property (@(posedge clk_i) disable iff (rst_i)
                           !ctrl.clear_n && count_o != `SPC_ZERO);
  c_carry: cover property (@(posedge clk_i) disable iff (rst_i)
                           carry_o);

endmodule // spc_counter
`default_nettype wire

// ===== verilog/spc_defines.svh
/*
  Constants of the presettable 4-bit counter: register offsets, field
  positions, reset values and terminal counts.
  Assumes inclusion by bare name from the counter's files.
*/
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define SPC_CTRL_OFS     4'h0
`define SPC_STATUS_OFS   4'h4

// ************************************************************
// Field positions and values
// ************************************************************
`define SPC_CTRL_W       8
`define SPC_CTRL_RST     8'h0c
`define SPC_STAT_CARRY   4
`define SPC_ZERO         4'h0
`define SPC_ONE          4'h1
`define SPC_TERM_DEC     4'h9
`define SPC_TERM_BIN     4'hf

`endif

// ===== verilog/spc_pkg.sv
/*
  Types of the presettable 4-bit counter.
  Assumes spc_defines.svh for all numeric constants.
*/
`default_nettype none
package spc_pkg;
  // Control register layout, msb first
  typedef struct packed {
    logic [3:0] preset;
    logic       clear_n;
    logic       load_n;
    logic       en_t;
    logic       en_p;
  } spc_ctrl_t;
endpackage
`default_nettype wire
